// File: pkg/phy_irq_pkg.sv
// Purpose: shared constants and carriers for the phy event interrupt status block
// Assumes: 32-bit Avalon-MM slave with byte addresses, one register per aligned word
// Notes: printed offsets are register indices; byte address is four times the index
`default_nettype none
package phy_irq_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int REG_W = 16;
   localparam int FLAG_NUM = 8;
   localparam int FLAG_LSB = 8;
   localparam int EN_LSB = 0;

   // register indices and the byte addresses derived from them
   localparam logic [7:0] FIRST_IRQ_IDX = 8'h12;
   localparam logic [7:0] SECOND_IRQ_IDX = 8'h13;
   localparam logic [ADDR_W-1:0] FIRST_IRQ_ADDR = {FIRST_IRQ_IDX[5:0], 2'b00};
   localparam logic [ADDR_W-1:0] SECOND_IRQ_ADDR = {SECOND_IRQ_IDX[5:0], 2'b00};

   // first register fields
   localparam int FC_HF_EN_BIT = 1;
   localparam int RX_HF_EN_BIT = 0;
   localparam int FIRST_EN_W = 2;

   // flag and enable index inside the second register (flag at FLAG_LSB+idx)
   localparam int EEE_ERR_IDX = 7;
   localparam int AN_ERR_IDX = 6;
   localparam int PAGE_RX_IDX = 5;
   localparam int LB_FLOW_IDX = 4;
   localparam int XOVER_IDX = 3;
   localparam int SLEEP_IDX = 2;
   localparam int POL_WOL_IDX = 1;
   localparam int JABBER_IDX = 0;

   // counter thresholds: half full is reached when the count exceeds these
   localparam logic [7:0] FC_HALF_FULL = 8'h7F;
   localparam logic [15:0] RX_HALF_FULL = 16'h007F;

   localparam logic [FIRST_EN_W-1:0] FIRST_EN_RESET = 2'h0;
   localparam logic [FLAG_NUM-1:0] SECOND_EN_RESET = 8'h00;
   localparam logic [FLAG_NUM-1:0] FLAG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [BE_W-1:0] byteenable;
      logic [DATA_W-1:0] writedata;
   } av_req_s;

   typedef struct packed {
      logic eee_error;
      logic an_error;
      logic page_received;
      logic loopback_overflow_underflow;
      logic crossover_change;
      logic sleep_event;
      logic polarity_change;
      logic wol_packet;
      logic jabber;
   } phy_event_s;
endpackage
`default_nettype wire

// File: rtl/event_latch_bank.sv
// Purpose: bank of latched-high event flags
// Assumes: events and clears come from logic on mclk_i
// Notes: a set in the same cycle as its clear wins, so no event is lost
`timescale 1ns/1ps
`default_nettype none
module event_latch_bank
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [phy_irq_pkg::FLAG_NUM-1:0] event_i,
   input wire logic [phy_irq_pkg::FLAG_NUM-1:0] clear_i,
   output logic [phy_irq_pkg::FLAG_NUM-1:0] flag_o
);
   import phy_irq_pkg::*;

   logic [FLAG_NUM-1:0] flag_q;

   genvar k;
   generate
      for (k = 0; k < FLAG_NUM; k++)
      begin : g_flag
         always_ff @(posedge mclk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               flag_q[k] <= FLAG_RESET[k];
            end
            else if (event_i[k])
            begin
               flag_q[k] <= 1'b1;
            end
            else if (clear_i[k])
            begin
               flag_q[k] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flag_o = flag_q;
endmodule // event_latch_bank
`default_nettype wire

// File: rtl/phy_event_interrupt_status.sv
// Purpose: interrupt enables and latched event status of a 10/100 transceiver
// Assumes: event strobes and counter values come from logic on mclk_i
// Notes: Avalon-MM slave with waitrequest; every access answers one cycle after it is seen
`timescale 1ns/1ps
`default_nettype none
module phy_event_interrupt_status
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire phy_irq_pkg::av_req_s av_req_i,
   input wire logic [7:0] fc_count_i,
   input wire logic [15:0] rx_err_count_i,
   input wire phy_irq_pkg::phy_event_s events_i,
   output logic [phy_irq_pkg::DATA_W-1:0] av_readdata_o,
   output logic av_waitrequest_o,
   output logic irq_o
);
   import phy_irq_pkg::*;

   logic req;
   logic prep;
   logic commit;
   logic hit_first;
   logic hit_second;
   logic waitreq_q;
   logic [DATA_W-1:0] readdata_q;
   logic [DATA_W-1:0] rd_word_d;
   logic [FLAG_NUM-1:0] rd_flags_q;
   logic [FLAG_NUM-1:0] rd_flags_d;
   logic [FLAG_NUM-1:0] clear_vec;
   logic [FLAG_NUM-1:0] event_vec;
   logic [FLAG_NUM-1:0] flags;
   logic [FIRST_EN_W-1:0] first_en_q;
   logic [FLAG_NUM-1:0] second_en_q;
   logic fc_half_full;
   logic rx_half_full;
   logic irq_d;
   logic irq_q;

   // request phases: prep is the cycle the access is first seen, commit the acked one
   assign req = av_req_i.read | av_req_i.write;
   assign prep = req & waitreq_q;
   assign commit = req & ~waitreq_q;
   assign hit_first = (av_req_i.address == FIRST_IRQ_ADDR);
   assign hit_second = (av_req_i.address == SECOND_IRQ_ADDR);

   // collapse the event sources onto the flag positions
   always_comb
   begin
      event_vec = FLAG_RESET;
      event_vec[EEE_ERR_IDX] = events_i.eee_error;
      event_vec[AN_ERR_IDX] = events_i.an_error;
      event_vec[PAGE_RX_IDX] = events_i.page_received;
      event_vec[LB_FLOW_IDX] = events_i.loopback_overflow_underflow;
      event_vec[XOVER_IDX] = events_i.crossover_change;
      event_vec[SLEEP_IDX] = events_i.sleep_event;
      // one shared flag: software cannot tell which source fired from this bit alone
      event_vec[POL_WOL_IDX] = events_i.polarity_change | events_i.wol_packet;
      event_vec[JABBER_IDX] = events_i.jabber;
   end

   // only bits that software actually saw as set are cleared, so a flag
   // raised between data capture and the acked edge survives the read
   assign clear_vec = (commit && av_req_i.read && hit_second) ? rd_flags_q : FLAG_RESET;

   event_latch_bank u_flags
   (
      .mclk_i (mclk_i),
      .rst_i (rst_i),
      .event_i (event_vec),
      .clear_i (clear_vec),
      .flag_o (flags)
   );

   // read mux; unmapped addresses read as zero
   always_comb
   begin
      rd_word_d = READ_ZERO;
      rd_flags_d = FLAG_RESET;
      if (hit_first)
      begin
         rd_word_d[FC_HF_EN_BIT] = first_en_q[FC_HF_EN_BIT];
         rd_word_d[RX_HF_EN_BIT] = first_en_q[RX_HF_EN_BIT];
      end
      else if (hit_second)
      begin
         rd_word_d[FLAG_LSB +: FLAG_NUM] = flags;
         rd_word_d[EN_LSB +: FLAG_NUM] = second_en_q;
         rd_flags_d = flags;
      end
   end

   // bus handshake: waitrequest drops for exactly one cycle per access
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         waitreq_q <= 1'b1;
      end
      else
      begin
         waitreq_q <= ~prep;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         readdata_q <= READ_ZERO;
         rd_flags_q <= FLAG_RESET;
      end
      else if (prep && av_req_i.read)
      begin
         readdata_q <= rd_word_d;
         rd_flags_q <= rd_flags_d;
      end
      else if (prep)
      begin
         readdata_q <= READ_ZERO;
         rd_flags_q <= FLAG_RESET;
      end
   end

   // first register: only the two counter enables exist
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         first_en_q <= FIRST_EN_RESET;
      end
      else if (commit && av_req_i.write && hit_first && av_req_i.byteenable[0])
      begin
         first_en_q <= av_req_i.writedata[FIRST_EN_W-1:0];
      end
   end

   // second register: low byte holds the enables, high byte flags are read only
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         second_en_q <= SECOND_EN_RESET;
      end
      else if (commit && av_req_i.write && hit_second && av_req_i.byteenable[0])
      begin
         second_en_q <= av_req_i.writedata[EN_LSB +: FLAG_NUM];
      end
   end

   // counter half-full levels stay up until the counters are read elsewhere
   assign fc_half_full = (fc_count_i > FC_HALF_FULL);
   assign rx_half_full = (rx_err_count_i > RX_HALF_FULL);

   always_comb
   begin
      irq_d = |(flags & second_en_q);
      irq_d = irq_d | (first_en_q[FC_HF_EN_BIT] & fc_half_full);
      irq_d = irq_d | (first_en_q[RX_HF_EN_BIT] & rx_half_full);
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= irq_d;
      end
   end

   assign av_readdata_o = readdata_q;
   assign av_waitrequest_o = waitreq_q;
   assign irq_o = irq_q;

   // bus behaviour checks
   chk_ack_one_cycle: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      prep |=> !av_waitrequest_o ##1 av_waitrequest_o)
   else $error("waitrequest did not pulse low for one cycle");

   chk_unmapped_zero: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (prep && av_req_i.read && !hit_first && !hit_second) |=> av_readdata_o == READ_ZERO)
   else $error("unmapped read returned nonzero data");

   chk_ack_needs_request: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !prep |=> av_waitrequest_o)
   else $error("waitrequest dropped with no new request");

   // read data stands until the next access is seen
   chk_readdata_stands: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !prep |=> $stable(av_readdata_o))
   else $error("read data changed between accesses");

   // enable registers
   chk_first_enable_write: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (commit && av_req_i.write && hit_first && av_req_i.byteenable[0])
      |=> first_en_q == $past(av_req_i.writedata[FIRST_EN_W-1:0]))
   else $error("first register enables not written");

   chk_second_enable_write: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (commit && av_req_i.write && hit_second && av_req_i.byteenable[0])
      |=> second_en_q == $past(av_req_i.writedata[EN_LSB +: FLAG_NUM]))
   else $error("second register enables not written");

   chk_enable_hold: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !(commit && av_req_i.write) |=> $stable(second_en_q) && $stable(first_en_q))
   else $error("enable register changed without a write");

   chk_second_readback: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (prep && av_req_i.read && hit_second)
      |=> av_readdata_o[EN_LSB +: FLAG_NUM] == $past(second_en_q)
          && av_readdata_o[FLAG_LSB +: FLAG_NUM] == $past(flags)
          && av_readdata_o[DATA_W-1:REG_W] == 16'h0000)
   else $error("second register read data wrong");

   chk_first_readback: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (prep && av_req_i.read && hit_first)
      |=> av_readdata_o == {{(DATA_W-FIRST_EN_W){1'b0}}, $past(first_en_q)})
   else $error("first register read data wrong");

   chk_lane_off_ignored: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (commit && av_req_i.write && !av_req_i.byteenable[0])
      |=> $stable(first_en_q) && $stable(second_en_q))
   else $error("enable written with byte lane 0 off");

   // interrupt relations
   chk_fc_half_full_irq: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (first_en_q[FC_HF_EN_BIT] && fc_count_i > FC_HALF_FULL) |=> irq_o)
   else $error("false carrier half full did not raise the interrupt");

   chk_fc_below_half: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (fc_count_i == FC_HALF_FULL && !first_en_q[RX_HF_EN_BIT] && (flags & second_en_q) == 8'h00)
      |=> !irq_o)
   else $error("interrupt raised at a count of exactly 7Fh");

   chk_rx_half_full_irq: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (first_en_q[RX_HF_EN_BIT] && rx_err_count_i > RX_HALF_FULL) |=> irq_o)
   else $error("receive error half full did not raise the interrupt");

   chk_rx_below_half: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (rx_err_count_i == RX_HALF_FULL && !first_en_q[FC_HF_EN_BIT]
       && (flags & second_en_q) == FLAG_RESET) |=> !irq_o)
   else $error("interrupt raised at a receive error count of exactly 7Fh");

   chk_flag_irq: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ((flags & second_en_q) != 8'h00) |=> irq_o)
   else $error("enabled pending flag did not raise the interrupt");

   chk_irq_release: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      ((flags & second_en_q) == 8'h00 && !(first_en_q[FC_HF_EN_BIT] && fc_half_full)
       && !(first_en_q[RX_HF_EN_BIT] && rx_half_full)) |=> !irq_o)
   else $error("interrupt held with no enabled source");

   chk_masked_flag_quiet: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (second_en_q == 8'h00 && first_en_q == 2'h0) |=> !irq_o)
   else $error("interrupt raised while every enable is clear");

   chk_wol_shares_flag: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (events_i.wol_packet && !events_i.polarity_change) |=> flags[POL_WOL_IDX])
   else $error("wake packet did not set the shared flag");

   chk_pol_shares_flag: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (events_i.polarity_change && !events_i.wol_packet) |=> flags[POL_WOL_IDX])
   else $error("polarity change did not set the shared flag");

   // per-flag latch behaviour
   genvar f;
   generate
      for (f = 0; f < FLAG_NUM; f++)
      begin : g_chk
         chk_flag_sets: assert property (
            @(posedge mclk_i) disable iff (rst_i)
            event_vec[f] |=> flags[f])
         else $error("event did not set its flag");

         chk_flag_holds: assert property (
            @(posedge mclk_i) disable iff (rst_i)
            (flags[f] && !(commit && av_req_i.read && hit_second)) |=> flags[f])
         else $error("flag dropped without a status read");

         chk_read_clears: assert property (
            @(posedge mclk_i) disable iff (rst_i)
            (commit && av_req_i.read && hit_second && rd_flags_q[f] && !event_vec[f])
            |=> !flags[f])
         else $error("status read did not clear the flag");

         chk_late_flag_kept: assert property (
            @(posedge mclk_i) disable iff (rst_i)
            (flags[f] && !rd_flags_q[f]) |=> flags[f])
         else $error("flag cleared although the read did not report it");

         chk_no_spurious: assert property (
            @(posedge mclk_i) disable iff (rst_i)
            (!flags[f] && !event_vec[f]) |=> !flags[f])
         else $error("flag set with no event");
      end
   endgenerate
endmodule // phy_event_interrupt_status
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: self-checking bench for the phy event interrupt status block
// Assumes: Avalon-MM master waits for waitrequest low; events and counts driven on mclk_i
// Notes: expectations come from bench functions; random values from a fixed-seed xorshift
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import phy_irq_pkg::*;
   logic mclk_i;
   logic rst_i;
   av_req_s req;
   logic [7:0] fc_cnt;
   logic [15:0] rx_cnt;
   phy_event_s ev;
   logic [31:0] rdata;
   logic wait_req;
   logic irq;
   logic [31:0] seed;
   logic [31:0] q;
   logic [31:0] m;
   logic [1:0] en;
   logic [7:0] fc_n;
   logic [15:0] rx_n;
   int f;
   int bad_count;
   int comparisons;
   logic [7:0] fc_tab [4] = '{8'h7F, 8'h80, 8'hFF, 8'h00};
   logic [15:0] rx_tab [4] = '{16'h0080, 16'h007F, 16'hFFFF, 16'h0100};
   // all corners but the third (both enables on) leave one enable off so each threshold is seen alone
   logic [1:0] en_tab [4] = '{2'h2, 2'h1, 2'h3, 2'h1};

   phy_event_interrupt_status phy_event_interrupt_status_inst
   (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .av_req_i(req),
      .fc_count_i(fc_cnt),
      .rx_err_count_i(rx_cnt),
      .events_i(ev),
      .av_readdata_o(rdata),
      .av_waitrequest_o(wait_req),
      .irq_o(irq)
   );

   initial mclk_i = 1'b0;
   always #2 mclk_i = ~mclk_i;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // struct is msb-first; polarity and wake packet share one flag
   function automatic int flag_of(input int k);
      return (k == 0) ? 8 : (k <= 2) ? 9 : k + 7;
   endfunction

   function automatic logic cnt_irq(input logic [7:0] fc, input logic [15:0] rx,
                                    input logic [1:0] e);
      return (e[1] && fc > 8'h7F) || (e[0] && rx > 16'h007F);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic test_done(input string name);
      $display("test %s done, mismatches %0d", name, bad_count);
   endtask

   // one edge passes before driving, so a release and a new request never share a step
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge mclk_i);
      req <= '{address: a, read: !w, write: w, byteenable: be, writedata: d};
      // only the watchdog ends a wait that never gets its answer
      do
      begin
         @(posedge mclk_i);
      end
      while (wait_req !== 1'b0);
      q = rdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'h0);
      chk(q, exp);
   endtask

   task automatic pulse(input int k);
      @(posedge mclk_i);
      ev <= phy_event_s'(9'h001 << k);
      @(posedge mclk_i);
      ev <= '0;
   endtask

   task automatic irq_after(input int n, input logic exp);
      repeat (n) @(posedge mclk_i);
      #1;
      chk({31'h0, irq}, {31'h0, exp});
   endtask

   initial
   begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      final_report();
   end

   initial
   begin
      rst_i = 1'b1;
      req = '0;
      fc_cnt = 8'h00;
      rx_cnt = 16'h0000;
      ev = '0;
      seed = 32'h6BDBA42B;
      bad_count = 0;
      comparisons = 0;
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(SECOND_IRQ_ADDR, READ_ZERO);
      rd(FIRST_IRQ_ADDR, READ_ZERO);
      test_done("reset");
      for (int i = 0; i < 16; i++)
      begin
         seed = xs(seed);
         wr(FIRST_IRQ_ADDR, seed);
         wr(SECOND_IRQ_ADDR, ~seed);
         rd(FIRST_IRQ_ADDR, seed & 32'h3);
         rd(SECOND_IRQ_ADDR, ~seed & 32'hFF);
      end
      // byte lane 0 off: the write must be dropped
      bus(1'b1, SECOND_IRQ_ADDR, seed, 4'h0);
      rd(SECOND_IRQ_ADDR, ~seed & 32'hFF);
      wr(8'h50, 32'hFFFF_FFFF);
      rd(8'h50, READ_ZERO);
      test_done("enables");
      wr(FIRST_IRQ_ADDR, 32'h0);
      for (int k = 0; k < 9; k++)
      begin
         f = flag_of(k);
         m = 32'h1 << (f - 8);
         wr(SECOND_IRQ_ADDR, m);
         pulse(k);
         irq_after(1, 1'b1);
         rd(SECOND_IRQ_ADDR, (32'h1 << f) | m);
         irq_after(1, 1'b0);
         wr(SECOND_IRQ_ADDR, ~m & 32'hFF);
         pulse(k);
         irq_after(2, 1'b0);
         rd(SECOND_IRQ_ADDR, (32'h1 << f) | (~m & 32'hFF));
         rd(SECOND_IRQ_ADDR, ~m & 32'hFF);
      end
      test_done("event flags");
      wr(SECOND_IRQ_ADDR, 32'h0);
      @(posedge mclk_i);
      ev <= phy_event_s'(9'h001);
      rd(SECOND_IRQ_ADDR, 32'h100);
      rd(SECOND_IRQ_ADDR, 32'h100);
      @(posedge mclk_i);
      ev <= '0;
      rd(SECOND_IRQ_ADDR, 32'h100);
      rd(SECOND_IRQ_ADDR, 32'h0);
      test_done("held event");
      for (int i = 0; i < 24; i++)
      begin
         seed = xs(seed);
         en = (i < 4) ? en_tab[i] : seed[1:0];
         fc_n = (i < 4) ? fc_tab[i] : seed[15:8];
         rx_n = (i < 4) ? rx_tab[i] : (seed[31] ? seed[31:16] : {8'h00, seed[23:16]});
         wr(FIRST_IRQ_ADDR, {30'h0, en});
         @(posedge mclk_i);
         fc_cnt <= fc_n;
         rx_cnt <= rx_n;
         irq_after(2, cnt_irq(fc_n, rx_n, en));
      end
      test_done("counters");
      wr(SECOND_IRQ_ADDR, 32'hFF);
      pulse(8);
      @(posedge mclk_i);
      rst_i <= 1'b1;
      irq_after(2, 1'b0);
      @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(SECOND_IRQ_ADDR, READ_ZERO);
      rd(FIRST_IRQ_ADDR, READ_ZERO);
      test_done("second reset");
      final_report();
   end
endmodule // tb_top
`default_nettype wire
